// >>> bbs_consts.svh
`ifndef BBS_CONSTS_SVH
`define BBS_CONSTS_SVH
`define BBS_CLK_PERIOD_NS 10
`define BBS_COARSE_TICK_MS 100
`define BBS_COARSE_CYCLES (`BBS_COARSE_TICK_MS * 1000000 / `BBS_CLK_PERIOD_NS)
`define BBS_FINE_TICK_US 100
`define BBS_FINE_CYCLES (`BBS_FINE_TICK_US * 1000 / `BBS_CLK_PERIOD_NS)
`define BBS_TICKS_PER_S 10
`define BBS_FINE_PER_MS 10
`define BBS_TMR_MIN_S 10
`define BBS_TMR_MAX_S 120
`define BBS_FADE_MIN_MS 300
`define BBS_FADE_MAX_MS 5500
`define BBS_SEL_SPAN 14
`define BBS_CODE_FULL 127
`define BBS_CUBIC1_K 153
`define BBS_CUBIC2_K 179
`define BBS_CUBIC_SHIFT 7
`define BBS_I2C_ADDR 7'h2A
`define BBS_REG_MODE 8'h00
`define BBS_REG_CTRL 8'h02
`define BBS_REG_TIMERS 8'h03
`define BBS_REG_FADES 8'h04
`define BBS_REG_LVL_BASE 8'h05
`define BBS_REG_STATUS 8'h0B
`define BBS_LVL_COUNT 6
`define BBS_MODE_STNBY_BIT 0
`define BBS_MODE_ON_BIT 1
`define BBS_MODE_DIM_BIT 2
`define BBS_RST_BYTE 8'h00
`define BBS_RST_CODE 7'h00
`endif

// >>> bbs_pkg.sv
package bbs_pkg;
    typedef enum logic [2:0] {
        RAMP_HOLD = 3'b001,
        RAMP_UP = 3'b010,
        RAMP_DOWN = 3'b100
    } bbs_ramp_t;
    typedef enum logic [4:0] {
        I2C_IDLE = 5'b00001,
        I2C_ADDR = 5'b00010,
        I2C_REG = 5'b00100,
        I2C_WR = 5'b01000,
        I2C_RD = 5'b10000
    } bbs_i2c_t;
    typedef enum logic [1:0] {
        LAW_LINEAR = 2'b00,
        LAW_SQUARE = 2'b01,
        LAW_CUBIC1 = 2'b10,
        LAW_CUBIC2 = 2'b11
    } bbs_law_t;
    typedef struct packed {
        logic spare1;
        logic spare0;
        logic fadeBypass;
        logic keyWake;
        logic [1:0] level;
        bbs_law_t law;
    } bbs_ctrl_t;
endpackage

// >>> bbs_backlight_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbs_consts.svh"

// Contract
// - max and dim settings are 7-bit codes
// - law 00: current proportional to code
// - law 01: current follows code squared
// - laws 10 and 11 are cubic fades
// - operating mode: on bit switches backlight
// - dim bit selects dim, clear selects max
// - dim above max is not clamped
// - keypad key press sets on bit
// - dim timer sets dim bit on expiry
// - dim clear or retrigger restarts dim countdown
// - off timer clears on bit on expiry
// - retrigger resets countdowns, clear turns off
// - timers step max, dim, then off
// - upward moves ramp by fade-up time
// - fade time spans full scale ramp
// - downward moves ramp by fade-down time
// - retrigger during fade-down reverses upward
// - fade up and down independently enabled
// - bypass bit: retrigger during a fade jumps to max
// - linear and square step at fixed rate
// - cubic steps quicken as code rises
// - cubic fades finish 30% or 10% sooner
// - level field picks max/dim register pair
module bbs_backlight_sequencer #(
    parameter int unsigned COARSE_CYCLES = `BBS_COARSE_CYCLES,
    parameter int unsigned FINE_CYCLES = `BBS_FINE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOutEn_n,
    input wire logic keypadMode,
    input wire logic keyPress,
    output logic [6:0] sinkCode,
    output logic backlightOn,
    output bbs_pkg::bbs_ramp_t rampState
);
    import bbs_pkg::*;

    function automatic logic regHit(input logic en, input logic [7:0] a, input logic [7:0] b);
        return en && (a == b);
    endfunction

    function automatic logic [11:0] tmrTicks(input logic [3:0] sel);
        int s;
        s = `BBS_TMR_MIN_S + (int'(sel) - 1) * (`BBS_TMR_MAX_S - `BBS_TMR_MIN_S) / `BBS_SEL_SPAN;
        return 12'(s * `BBS_TICKS_PER_S);
    endfunction

    function automatic logic [15:0] stepLen(input logic [3:0] sel, input bbs_law_t law, input logic [6:0] code);
        int ms;
        int len;
        ms = `BBS_FADE_MIN_MS + (int'(sel) - 1) * (`BBS_FADE_MAX_MS - `BBS_FADE_MIN_MS) / `BBS_SEL_SPAN;
        len = ms * `BBS_FINE_PER_MS / `BBS_CODE_FULL;
        if (law == LAW_CUBIC1)
        begin
            len = (len * (`BBS_CUBIC1_K - int'(code))) >> `BBS_CUBIC_SHIFT;
        end
        else if (law == LAW_CUBIC2)
        begin
            len = (len * (`BBS_CUBIC2_K - int'(code))) >> `BBS_CUBIC_SHIFT;
        end
        if (len < 1)
        begin
            len = 1;
        end
        return 16'(len);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial port: synchronisers and bus state
    logic [1:0] sclSync_q;
    logic [1:0] sdaSync_q;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic sclNow;
    logic sdaNow;
    logic startSeen;
    logic stopSeen;
    logic sclRise;
    logic sclFall;
    bbs_i2c_t i2c_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic readDir_q;
    logic drvLow_q;
    logic wrEn_q;
    logic [7:0] wrAddr_q;
    logic [7:0] wrData_q;
    logic [7:0] rdByte;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    assign sclNow = sclSync_q[1];
    assign sdaNow = sdaSync_q[1];
    assign startSeen = sclNow && sclPrev_q && sdaPrev_q && !sdaNow;
    assign stopSeen = sclNow && sclPrev_q && !sdaPrev_q && sdaNow;
    assign sclRise = sclNow && !sclPrev_q;
    assign sclFall = !sclNow && sclPrev_q;
    assign sdaOut = 1'b0;
    assign sdaOutEn_n = !drvLow_q;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            i2c_q <= I2C_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            readDir_q <= 1'b0;
            drvLow_q <= 1'b0;
            wrEn_q <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
        end
        else
        begin
            wrEn_q <= 1'b0;
            if (startSeen)
            begin
                i2c_q <= I2C_ADDR;
                bitCnt_q <= 4'h0;
                drvLow_q <= 1'b0;
            end
            else if (stopSeen)
            begin
                i2c_q <= I2C_IDLE;
                drvLow_q <= 1'b0;
            end
            else if (sclRise && i2c_q != I2C_IDLE)
            begin
                if (bitCnt_q < 4'h8)
                begin
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (i2c_q != I2C_RD)
                    begin
                        shift_q <= {shift_q[6:0], sdaNow};
                    end
                end
                else if (bitCnt_q == 4'h9 && i2c_q == I2C_RD && sdaNow)
                begin
                    i2c_q <= I2C_IDLE;
                end
            end
            else if (sclFall && i2c_q != I2C_IDLE)
            begin
                if (bitCnt_q == 4'h8)
                begin
                    bitCnt_q <= 4'h9;
                    case (i2c_q)
                        I2C_ADDR:
                        begin
                            if (shift_q[7:1] == `BBS_I2C_ADDR)
                            begin
                                drvLow_q <= 1'b1;
                                readDir_q <= shift_q[0];
                            end
                            else
                            begin
                                i2c_q <= I2C_IDLE;
                            end
                        end
                        I2C_REG:
                        begin
                            ptr_q <= shift_q;
                            drvLow_q <= 1'b1;
                        end
                        I2C_WR:
                        begin
                            wrEn_q <= 1'b1;
                            wrAddr_q <= ptr_q;
                            wrData_q <= shift_q;
                            ptr_q <= ptr_q + 8'h01;
                            drvLow_q <= 1'b1;
                        end
                        default:
                        begin
                            drvLow_q <= 1'b0;
                        end
                    endcase
                end
                else if (bitCnt_q == 4'h9)
                begin
                    bitCnt_q <= 4'h0;
                    if (i2c_q == I2C_RD || (i2c_q == I2C_ADDR && readDir_q))
                    begin
                        i2c_q <= I2C_RD;
                        shift_q <= rdByte;
                        drvLow_q <= !rdByte[7];
                        ptr_q <= ptr_q + 8'h01;
                    end
                    else
                    begin
                        drvLow_q <= 1'b0;
                        if (i2c_q == I2C_ADDR)
                        begin
                            i2c_q <= I2C_REG;
                        end
                        else
                        begin
                            i2c_q <= I2C_WR;
                        end
                    end
                end
                else if (i2c_q == I2C_RD)
                begin
                    shift_q <= {shift_q[6:0], 1'b0};
                    drvLow_q <= !shift_q[6];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic stnby_q;
    logic on_q;
    logic dim_q;
    bbs_ctrl_t ctrl_q;
    logic [7:0] timers_q;
    logic [7:0] fades_q;
    logic [6:0] level_q [`BBS_LVL_COUNT];
    logic [6:0] code_q;
    logic hostMode;
    logic keyWake;
    logic retrig;
    logic lit;
    logic dimExpire;
    logic offExpire;

    assign hostMode = regHit(wrEn_q, wrAddr_q, `BBS_REG_MODE);
    assign keyWake = keypadMode && ctrl_q.keyWake && keyPress;
    assign retrig = (hostMode && wrData_q[`BBS_MODE_ON_BIT]) || keyWake;
    assign lit = on_q && stnby_q;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stnby_q <= 1'b0;
            on_q <= 1'b0;
            dim_q <= 1'b0;
        end
        else
        begin
            if (hostMode)
            begin
                stnby_q <= wrData_q[`BBS_MODE_STNBY_BIT];
            end
            if (retrig)
            begin
                on_q <= 1'b1;
            end
            else if (offExpire)
            begin
                on_q <= 1'b0;
            end
            else if (hostMode)
            begin
                on_q <= wrData_q[`BBS_MODE_ON_BIT];
            end
            if (dimExpire)
            begin
                dim_q <= 1'b1;
            end
            else if (hostMode)
            begin
                dim_q <= wrData_q[`BBS_MODE_DIM_BIT];
            end
            else if (retrig)
            begin
                dim_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= bbs_ctrl_t'(`BBS_RST_BYTE);
            timers_q <= `BBS_RST_BYTE;
            fades_q <= `BBS_RST_BYTE;
        end
        else
        begin
            if (regHit(wrEn_q, wrAddr_q, `BBS_REG_CTRL))
            begin
                ctrl_q <= bbs_ctrl_t'(wrData_q);
            end
            if (regHit(wrEn_q, wrAddr_q, `BBS_REG_TIMERS))
            begin
                timers_q <= wrData_q;
            end
            if (regHit(wrEn_q, wrAddr_q, `BBS_REG_FADES))
            begin
                fades_q <= wrData_q;
            end
        end
    end

    // brightness code registers, max/dim pair per level
    for (genvar i = 0; i < `BBS_LVL_COUNT; i++)
    begin : g_level
        always_ff @(posedge sys_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                level_q[i] <= `BBS_RST_CODE;
            end
            else if (regHit(wrEn_q, wrAddr_q, `BBS_REG_LVL_BASE + 8'(i)))
            begin
                level_q[i] <= wrData_q[6:0];
            end
        end
    end

    always_comb
    begin
        rdByte = 8'h00;
        case (ptr_q)
            `BBS_REG_MODE: rdByte = {5'h00, dim_q, on_q, stnby_q};
            `BBS_REG_CTRL: rdByte = ctrl_q;
            `BBS_REG_TIMERS: rdByte = timers_q;
            `BBS_REG_FADES: rdByte = fades_q;
            `BBS_REG_STATUS: rdByte = {lit, code_q};
            default:
            begin
                if (ptr_q >= `BBS_REG_LVL_BASE && ptr_q < `BBS_REG_STATUS)
                begin
                    rdByte = {1'b0, level_q[3'(ptr_q - `BBS_REG_LVL_BASE)]};
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // dim and off timers
    logic [23:0] coarse_q;
    logic coarseTick;
    logic [11:0] dimCnt_q;
    logic [11:0] offCnt_q;
    logic dimRestart;

    assign coarseTick = (coarse_q == 24'(COARSE_CYCLES - 1));
    assign dimRestart = retrig || (hostMode && dim_q && !wrData_q[`BBS_MODE_DIM_BIT]);
    assign dimExpire = lit && !dim_q && timers_q[3:0] != 4'h0 && dimCnt_q >= tmrTicks(timers_q[3:0]);
    assign offExpire = lit && timers_q[7:4] != 4'h0 && offCnt_q >= tmrTicks(timers_q[7:4]);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            coarse_q <= 24'h000000;
            dimCnt_q <= 12'h000;
            offCnt_q <= 12'h000;
        end
        else
        begin
            coarse_q <= coarseTick ? 24'h000000 : coarse_q + 24'h000001;
            if (dimRestart || !lit || dim_q || timers_q[3:0] == 4'h0)
            begin
                dimCnt_q <= 12'h000;
            end
            else if (coarseTick && !dimExpire)
            begin
                dimCnt_q <= dimCnt_q + 12'h001;
            end
            if (retrig || !lit || timers_q[7:4] == 4'h0)
            begin
                offCnt_q <= 12'h000;
            end
            else if (coarseTick && !offExpire)
            begin
                offCnt_q <= offCnt_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fade ramp
    logic [15:0] fine_q;
    logic fineTick;
    logic [15:0] stepCnt_q;
    logic [2:0] maxIdx;
    logic [6:0] maxCode;
    logic [6:0] targetCode;
    logic [3:0] fadeSel;
    logic [15:0] stepNow;
    logic stepDue;

    assign fineTick = (fine_q == 16'(FINE_CYCLES - 1));
    assign maxIdx = (ctrl_q.level == 2'h0) ? 3'h0 : ((ctrl_q.level == 2'h1) ? 3'h2 : 3'h4);
    assign maxCode = level_q[maxIdx];
    assign targetCode = !lit ? `BBS_RST_CODE : (dim_q ? level_q[maxIdx + 3'h1] : maxCode);
    assign fadeSel = (code_q < targetCode) ? fades_q[3:0] : fades_q[7:4];
    assign stepNow = stepLen(fadeSel, ctrl_q.law, code_q);
    assign stepDue = fineTick && (stepCnt_q + 16'h0001 >= stepNow);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fine_q <= 16'h0000;
            stepCnt_q <= 16'h0000;
            code_q <= `BBS_RST_CODE;
        end
        else
        begin
            fine_q <= fineTick ? 16'h0000 : fine_q + 16'h0001;
            if (retrig && ctrl_q.fadeBypass && rampState != RAMP_HOLD)
            begin
                code_q <= maxCode;
                stepCnt_q <= 16'h0000;
            end
            else if (code_q == targetCode)
            begin
                stepCnt_q <= 16'h0000;
            end
            else if (fadeSel == 4'h0)
            begin
                code_q <= targetCode;
                stepCnt_q <= 16'h0000;
            end
            else if (stepDue)
            begin
                stepCnt_q <= 16'h0000;
                if (code_q < targetCode)
                begin
                    code_q <= code_q + 7'h01;
                end
                else
                begin
                    code_q <= code_q - 7'h01;
                end
            end
            else if (fineTick)
            begin
                stepCnt_q <= stepCnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rampState <= RAMP_HOLD;
        end
        else
        begin
            case (1'b1)
                (code_q < targetCode): rampState <= RAMP_UP;
                (code_q > targetCode): rampState <= RAMP_DOWN;
                default: rampState <= RAMP_HOLD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer law to sink level
    logic [13:0] codeSq;

    assign codeSq = {7'h00, code_q} * {7'h00, code_q};

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sinkCode <= `BBS_RST_CODE;
            backlightOn <= 1'b0;
        end
        else
        begin
            backlightOn <= lit;
            if (ctrl_q.law == LAW_LINEAR)
            begin
                sinkCode <= code_q;
            end
            else
            begin
                sinkCode <= 7'(codeSq / 14'(`BBS_CODE_FULL));
            end
        end
    end
endmodule // bbs_backlight_sequencer
`default_nettype wire

// >>> bbs_backlight_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bbs_backlight_sequencer_checker #(
    parameter int unsigned COARSE_CYCLES = 10,
    parameter int unsigned FINE_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOutEn_n,
    input wire logic keypadMode,
    input wire logic keyPress,
    input wire logic [6:0] sinkCode,
    input wire logic backlightOn,
    input wire bbs_pkg::bbs_ramp_t rampState
);
    import bbs_pkg::*;
    localparam int RAMP_LIMIT = 128 * 600 * FINE_CYCLES;
    int runLen_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////
    // length of the present ramp
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            runLen_q <= 0;
        else
            runLen_q <= (rampState == RAMP_HOLD) ? 0 : runLen_q + 1;
    end
    ////////////////////////////////
    a_reset_idle: assert property ($rose(resetn) |-> sinkCode == 7'h00 && !backlightOn
        && rampState == RAMP_HOLD && sdaOutEn_n)
        else $error("not idle after reset");
    a_state_onehot: assert property ($onehot(rampState))
        else $error("ramp state not one-hot");
    a_off_zero: assert property ((!backlightOn && rampState == RAMP_HOLD) [*3] |-> sinkCode == 7'h00)
        else $error("level not zero while off");
    a_up_rises: assert property ((rampState == RAMP_UP) [*3] |-> sinkCode >= $past(sinkCode))
        else $error("level falls during fade up");
    a_down_falls: assert property ((rampState == RAMP_DOWN) [*3] |-> sinkCode <= $past(sinkCode))
        else $error("level rises during fade down");
    a_step_small: assert property ((rampState != RAMP_HOLD) [*3] |->
        7'(sinkCode - $past(sinkCode) + 7'h02) <= 7'h04)
        else $error("fade step too large");
    a_off_no_up: assert property ($fell(backlightOn) |-> ##2 rampState != RAMP_UP)
        else $error("fading up after turn off");
    a_ramp_bounded: assert property (rampState != RAMP_HOLD |-> runLen_q < RAMP_LIMIT)
        else $error("ramp never ends");
endmodule // bbs_backlight_sequencer_checker
bind bbs_backlight_sequencer bbs_backlight_sequencer_checker #(
    .COARSE_CYCLES(COARSE_CYCLES),
    .FINE_CYCLES(FINE_CYCLES)
) chk_u (
    .sys_clk,
    .resetn,
    .sclIn,
    .sdaIn,
    .sdaOut,
    .sdaOutEn_n,
    .keypadMode,
    .keyPress,
    .sinkCode,
    .backlightOn,
    .rampState
);
`default_nettype wire

// >>> bbs_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbs_consts.svh"
module bbs_i2c_host (
    input wire logic sys_clk,
    input wire logic sdaOutEn_n,
    output var logic sclLine,
    output logic sdaLine
);
    logic sdaPull_q;
    initial
    begin
        sclLine = 1'b1;
        sdaPull_q = 1'b0;
    end
    // open-drain data wire with pull-up
    assign sdaLine = !(sdaPull_q || !sdaOutEn_n);
    task automatic step(input logic scl, input logic pull);
        repeat (5) @(posedge sys_clk);
        sclLine <= scl;
        sdaPull_q <= pull;
    endtask
    task automatic put_bit(input logic b);
        step(1'b0, !b);
        step(1'b1, !b);
        step(1'b0, !b);
    endtask
    task automatic get_bit(output logic b);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        repeat (3) @(posedge sys_clk);
        b = sdaLine;
        step(1'b0, 1'b0);
    endtask
    task automatic send(input logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
    endtask
    task automatic start();
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic write_reg(input logic [7:0] rg, input logic [7:0] d);
        start();
        send({`BBS_I2C_ADDR, 1'b0});
        send(rg);
        send(d);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] rg, output logic [7:0] d);
        start();
        send({`BBS_I2C_ADDR, 1'b0});
        send(rg);
        start();
        send({`BBS_I2C_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(1'b1);
        stop();
    endtask
endmodule // bbs_i2c_host
`default_nettype wire

// >>> bbs_backlight_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbs_consts.svh"
module bbs_backlight_sequencer_tb;
    import bbs_pkg::*;
    logic sys_clk;
    logic resetn;
    logic keypadMode;
    logic keyPress;
    wire logic sclLine;
    wire logic sdaLine;
    logic sdaOut;
    logic sdaOutEn_n;
    logic [6:0] sinkCode;
    logic backlightOn;
    bbs_ramp_t rampState;
    int fails;
    int checks;
    logic [6:0] maxT [3] = '{7'h64, 7'h50, 7'h7F};
    logic [6:0] dimT [3] = '{7'h70, 7'h10, 7'h08};
    bbs_backlight_sequencer #(
        .COARSE_CYCLES(10),
        .FINE_CYCLES(4)
    ) dut_u (
        .sys_clk,
        .resetn,
        .sclIn(sclLine),
        .sdaIn(sdaLine),
        .sdaOut,
        .sdaOutEn_n,
        .keypadMode,
        .keyPress,
        .sinkCode,
        .backlightOn,
        .rampState
    );
    bbs_i2c_host host_u (
        .sys_clk,
        .sdaOutEn_n,
        .sclLine,
        .sdaLine
    );
    ////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [6:0] law_map(input logic [1:0] law, input logic [6:0] c);
        return (law == 2'b00) ? c : 7'(({7'h00, c} * {7'h00, c}) / 14'h007F);
    endfunction
    function automatic logic [7:0] inr(input int v, input int lo, input int hi);
        return 8'(v >= lo && v <= hi);
    endfunction
    task automatic wr(input logic [7:0] rg, input logic [7:0] d);
        host_u.write_reg(rg, d);
    endtask
    task automatic rd(input logic [7:0] rg, input logic [7:0] exp);
        logic [7:0] d;
        host_u.read_reg(rg, d);
        check(d, exp, "read");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wait_code(input logic [6:0] t, input int lim, output int el);
        el = 0;
        while (sinkCode !== t && el < lim)
        begin
            @(negedge sys_clk);
            el++;
        end
    endtask
    task automatic key_pulse(input logic mode);
        @(posedge sys_clk);
        keypadMode <= mode;
        @(posedge sys_clk);
        keyPress <= 1'b1;
        @(posedge sys_clk);
        keyPress <= 1'b0;
        cyc(6);
    endtask
    ////////////////////////////////
    task automatic s_regs();
        rd(`BBS_REG_MODE, `BBS_RST_BYTE);
        rd(`BBS_REG_FADES, `BBS_RST_BYTE);
        wr(`BBS_REG_TIMERS, 8'hA5);
        rd(`BBS_REG_TIMERS, 8'hA5);
        rd(8'h20, 8'h00);
        wr(`BBS_REG_TIMERS, 8'h00);
        check({6'h00, sdaOut, backlightOn}, 8'h00, "reset lit");
    endtask
    task automatic s_laws();
        for (int l = 0; l < 3; l++)
        begin
            wr(8'h05 + 8'(2 * l), {1'b0, maxT[l]});
            wr(8'h06 + 8'(2 * l), {1'b1, dimT[l]});
        end
        rd(8'h06, {1'b0, dimT[0]});
        wr(`BBS_REG_MODE, 8'h03);
        for (int l = 0; l < 3; l++)
            for (int w = 0; w < 4; w++)
            begin
                wr(`BBS_REG_CTRL, 8'(l * 4 + w));
                cyc(8);
                check({1'b0, sinkCode}, {1'b0, law_map(2'(w), maxT[l])}, "law level");
            end
        wr(`BBS_REG_MODE, 8'h07);
        cyc(8);
        check({1'b0, sinkCode}, {1'b0, law_map(2'h3, dimT[2])}, "no dim");
        wr(`BBS_REG_MODE, 8'h01);
        cyc(8);
        check({sinkCode, backlightOn}, 8'h00, "not off");
        wr(`BBS_REG_MODE, 8'h02);
        cyc(8);
        check({7'h00, backlightOn}, 8'h00, "standby lit");
    endtask
    task automatic s_timers();
        int el;
        int el2;
        wr(`BBS_REG_CTRL, 8'h00);
        wr(`BBS_REG_TIMERS, 8'h31);
        wr(`BBS_REG_MODE, 8'h03);
        cyc(600);
        wr(`BBS_REG_MODE, 8'h03);
        wait_code(dimT[0], 1200, el);
        check(inr(el, 930, 1010), 8'h01, "dim delay");
        wr(`BBS_REG_MODE, 8'h03);
        cyc(4);
        check({1'b0, sinkCode}, {1'b0, maxT[0]}, "no max");
        wait_code(dimT[0], 1200, el);
        check(inr(el, 930, 1010), 8'h01, "dim restart");
        wait_code(7'h00, 1800, el2);
        check(inr(el + el2, 2420, 2510), 8'h01, "off delay");
        check({7'h00, backlightOn}, 8'h00, "still lit");
    endtask
    task automatic s_key();
        wr(`BBS_REG_TIMERS, 8'h00);
        wr(`BBS_REG_CTRL, 8'h10);
        key_pulse(1'b0);
        check({7'h00, backlightOn}, 8'h00, "no keypad");
        wr(`BBS_REG_CTRL, 8'h00);
        key_pulse(1'b1);
        check({7'h00, backlightOn}, 8'h00, "wake off");
        wr(`BBS_REG_CTRL, 8'h10);
        key_pulse(1'b1);
        check({sinkCode, backlightOn}, {maxT[0], 1'b1}, "no wake");
    endtask
    task automatic s_fade();
        int el;
        wr(`BBS_REG_MODE, 8'h01);
        wr(`BBS_REG_FADES, 8'h11);
        wr(`BBS_REG_MODE, 8'h03);
        cyc(200);
        check({5'h00, rampState}, {5'h00, RAMP_UP}, "no up");
        wait_code(maxT[0], 9800, el);
        check(inr(el + 200, 9050, 9350), 8'h01, "up time");
        wr(`BBS_REG_MODE, 8'h01);
        cyc(100);
        check({5'h00, rampState}, {5'h00, RAMP_DOWN}, "no down");
        cyc(1800);
        wr(`BBS_REG_MODE, 8'h03);
        cyc(30);
        check({5'h00, rampState}, {5'h00, RAMP_UP}, "no reversal");
        check(inr(int'(sinkCode), 66, 84), 8'h01, "rev point");
        wait_code(maxT[0], 3000, el);
        wr(`BBS_REG_CTRL, 8'h20);
        wr(`BBS_REG_MODE, 8'h01);
        cyc(300);
        wr(`BBS_REG_MODE, 8'h03);
        cyc(6);
        check({rampState[0], sinkCode}, {1'b1, maxT[0]}, "no bypass");
        wr(`BBS_REG_FADES, 8'h01);
        wr(`BBS_REG_MODE, 8'h01);
        cyc(6);
        check({1'b0, sinkCode}, 8'h00, "no jump");
        wr(`BBS_REG_MODE, 8'h03);
        cyc(100);
        check({5'h00, rampState}, {5'h00, RAMP_UP}, "up lost");
    endtask
    ////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        complete_run();
    end
    initial
    begin
        fails = 0;
        checks = 0;
        resetn = 1'b0;
        keypadMode = 1'b0;
        keyPress = 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        s_regs();
        s_laws();
        s_timers();
        s_key();
        s_fade();
        complete_run();
    end
endmodule // bbs_backlight_sequencer_tb
`default_nettype wire
